// File: hdl/ocs_pkg.sv
// Shared constants for the oscillator clock select block
package ocs_pkg;

	// Register indices; each register is one aligned 32-bit word
	localparam logic [15:0] IDX_TB_STOP_CFG   = 16'h001D;
	localparam logic [15:0] IDX_MAIN_OPTION   = 16'hFFCF;
	localparam logic [15:0] IDX_OSC_STATUS    = 16'h0020;
	// Byte addresses are four times the index, so 18 address bits
	localparam logic [17:0] ADDR_TB_STOP_CFG  = {IDX_TB_STOP_CFG, 2'h0};
	localparam logic [17:0] ADDR_MAIN_OPTION  = {IDX_MAIN_OPTION, 2'h0};
	localparam logic [17:0] ADDR_OSC_STATUS   = {IDX_OSC_STATUS, 2'h0};

	// Field positions in the timebase and stop configuration register
	localparam int TB_SEL_LO_POS       = 0;
	localparam int STOP_RC_KEEP_POS    = 2;
	localparam int STOP_XTAL_KEEP_POS  = 3;
	localparam int STOP_INT_OFF_POS    = 4;
	// Field position of the main source select in the option byte
	localparam int MAIN_SEL_LO_POS     = 0;

	// Values after reset
	localparam logic [7:0] CFG_RESET    = 8'h00;
	localparam logic [7:0] OPTION_RESET = 8'h00;

	// Main source select codes
	localparam logic [1:0] MAIN_NONE = 2'h0;
	localparam logic [1:0] MAIN_INT  = 2'h1;
	localparam logic [1:0] MAIN_RC   = 2'h2;
	localparam logic [1:0] MAIN_XTAL = 2'h3;

	// Timebase source select codes
	localparam logic [1:0] TB_INT    = 2'h0;
	localparam logic [1:0] TB_RC     = 2'h1;
	localparam logic [1:0] TB_XTAL   = 2'h2;
	localparam logic [1:0] TB_UNUSED = 2'h3;

	// Power mode of the device
	typedef enum logic [1:0] {
		OCS_RUN  = 2'b00,
		OCS_WAIT = 2'b01,
		OCS_STOP = 2'b11,
		OCS_BRK  = 2'b10
	} ocs_mode_t;

endpackage : ocs_pkg

// File: hdl/ocs_sync.sv
// Three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/10ps
module ocs_sync (
	input  wire logic CLK,     // System clock
	input  wire logic RESET_N, // Synchronous reset, active low
	input  wire logic din,     // Asynchronous level
	output logic      dout     // Filtered level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} ocs_sync_t;

	ocs_sync_t st;
	ocs_sync_t next_st;

	// Output changes only when the last two stages agree
	always_comb begin
		next_st    = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3) begin
			next_st.q = st.s3;
		end
	end

	// State register
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.q;
endmodule : ocs_sync

// File: hdl/ocs_apb.sv
// APB slave decode for the oscillator select registers
`timescale 1ns/10ps
module ocs_apb (
	input  wire logic        psel,     // Select
	input  wire logic        penable,  // Access phase
	input  wire logic        pwrite,   // Direction
	input  wire logic [17:0] paddr,    // Byte address
	input  wire logic [7:0]  cfg,      // Config register value
	input  wire logic [7:0]  option,   // Option byte value
	input  wire logic [7:0]  status,   // Status value
	output logic             cfg_we,   // Write strobe for config
	output logic [31:0]      rdata,    // Read data
	output logic             slverr    // Unmapped address
);
	logic hit_cfg;
	logic hit_opt;
	logic hit_sta;

	// Address decode; the option byte is read only
	always_comb begin
		hit_cfg = (paddr == ocs_pkg::ADDR_TB_STOP_CFG);
		hit_opt = (paddr == ocs_pkg::ADDR_MAIN_OPTION);
		hit_sta = (paddr == ocs_pkg::ADDR_OSC_STATUS);
		cfg_we  = psel && penable && pwrite && hit_cfg;
		rdata   = 32'h00000000;
		if (hit_cfg) begin
			rdata = {24'h000000, cfg};
		end else if (hit_opt) begin
			rdata = {24'h000000, option};
		end else if (hit_sta) begin
			rdata = {24'h000000, status};
		end
		// Writes to read-only words are flagged too
		slverr = psel && penable &&
			(!(hit_cfg || hit_opt || hit_sta) || (pwrite && !hit_cfg));
	end
endmodule : ocs_apb

// File: hdl/ocs_top.sv
// Oscillator clock select: source choice, pin drive and power-mode gating
//
// Function
// (R1) The main source comes from a two-bit field of the option byte.
// (R2) Codes 01, 10, 11 pick internal, RC, crystal; 00 picks nothing.
// (R3) Output pin carries the crystal amplifier when crystal, else bus clock.
// (R4) Timebase source field: 00 internal, 01 RC, 10 crystal, 11 unused.
// (R5) RC or crystal reach the timebase only if also the main source.
// (R6) The internal oscillator runs after every reset whatever the choice.
// (R7) The watchdog always gets the internal oscillator clock.
// (R8) Software should not use the internal oscillator as PLL reference.
// (R9) Stop halts the RC or crystal unless its keep-on bit was set.
// (R10) Stop keeps the internal oscillator unless its off bit was set.
// (R11) Wait leaves all oscillators and clock outputs untouched.
// (R12) Break keeps the main reference clock running without a gap; a concurrent stop still wins and applies stop gating.
// (R13) The system integration enable gates all three oscillators.
// (R14) The PLL reference is a buffered copy of the main reference.
// (R15) RC and crystal never run together; one excludes the other.
// (R16) Selections are static after reset; no glitch-free switching; the timebase select can still be rewritten at any time.
`timescale 1ns/10ps
module ocs_top (
	input  wire logic        CLK,           // System clock, 10 MHz
	input  wire logic        RESET_N,       // Synchronous reset, active low
	input  wire logic        PSEL,          // APB select
	input  wire logic        PENABLE,       // APB access phase
	input  wire logic        PWRITE,        // APB direction
	input  wire logic [17:0] PADDR,         // APB byte address
	input  wire logic [31:0] PWDATA,        // APB write data
	output logic [31:0]      PRDATA,        // APB read data
	output logic             PREADY,        // APB ready
	output logic             PSLVERR,       // APB error
	input  wire logic [7:0]  OPTION_BYTE,   // Non-volatile option byte
	input  wire logic        OSC_ENABLE_FROM_SYSINT, // Oscillator enable
	input  wire logic        STOP_REQ,      // Stop mode active
	input  wire logic        WAIT_REQ,      // Wait mode active
	input  wire logic        BREAK_REQ,     // Debug break active
	input  wire logic        BUS_CLOCK,     // Internal bus clock
	input  wire logic        INTERNAL_OSC_CLOCK, // Internal osc raw clock
	input  wire logic        RC_OSC_CLOCK,  // RC osc raw clock
	input  wire logic        CRYSTAL_OSC_CLOCK,  // Crystal osc raw clock
	input  wire logic        XTAL_AMP_OUT,  // Crystal inverting amp output
	output logic             INTERNAL_OSC_EN, // Internal osc power enable
	output logic             RC_OSC_EN,     // RC osc power enable
	output logic             CRYSTAL_OSC_EN, // Crystal osc power enable
	output logic             MAIN_REF_CLOCK, // Main reference clock
	output logic             PLL_REF_CLOCK, // Buffered main reference
	output logic             TIMEBASE_REF_CLOCK, // Timebase reference
	output logic             WATCHDOG_REF_CLOCK, // Watchdog reference
	output logic             OSC_OUTPUT_PIN // Second oscillator pin
);
	typedef struct packed {
		logic [7:0]        cfg;
		logic [7:0]        option;
		logic              opt_loaded;
		ocs_pkg::ocs_mode_t mode;
		logic              stop_int_off;
		logic              stop_rc_keep;
		logic              stop_xtal_keep;
		logic              int_en;
		logic              rc_en;
		logic              xtal_en;
	} ocs_state_t;

	ocs_state_t st;
	ocs_state_t next_st;

	logic       stop_s;
	logic       cfg_we;
	logic [31:0] rdata;
	logic       slverr;
	logic [1:0] main_sel;
	logic [1:0] tb_sel;
	logic [7:0] status;
	logic       main_clk;

	// Stop request is a level from another block timing domain
	ocs_sync u_stop_sync (
		.CLK     (CLK),
		.RESET_N (RESET_N),
		.din     (STOP_REQ),
		.dout    (stop_s)
	);

	// Field extraction from the held copies
	assign main_sel = st.option[ocs_pkg::MAIN_SEL_LO_POS +: 2]; // (R1)
	assign tb_sel   = st.cfg[ocs_pkg::TB_SEL_LO_POS +: 2];

	// Status word shows live enables and mode
	assign status = {st.mode, 1'b0, st.xtal_en, st.rc_en, st.int_en,
		main_sel};

	ocs_apb u_apb (
		.psel    (PSEL),
		.penable (PENABLE),
		.pwrite  (PWRITE),
		.paddr   (PADDR),
		.cfg     (st.cfg),
		.option  (st.option),
		.status  (status),
		.cfg_we  (cfg_we),
		.rdata   (rdata),
		.slverr  (slverr)
	);

	// Zero-wait slave: every access completes in its first access cycle
	assign PREADY  = 1'b1;
	assign PRDATA  = rdata;
	assign PSLVERR = slverr;

	// Next-state logic: option capture, config write, mode and enables
	always_comb begin
		next_st = st;
		// Option captured once after reset release, then frozen
		if (!st.opt_loaded) begin
			next_st.option     = OPTION_BYTE; // (R1) (R16)
			next_st.opt_loaded = 1'b1;
		end
		if (cfg_we) begin
			next_st.cfg = PWDATA[7:0];
		end
		// Stop takes precedence; break and wait leave the clocks alone
		if (stop_s) begin
			next_st.mode = ocs_pkg::OCS_STOP;
		end else if (BREAK_REQ) begin
			next_st.mode = ocs_pkg::OCS_BRK; // (R12)
		end else if (WAIT_REQ) begin
			next_st.mode = ocs_pkg::OCS_WAIT; // (R11)
		end else begin
			next_st.mode = ocs_pkg::OCS_RUN;
		end
		// Stop bits are latched on entry, so late writes do not count
		if (stop_s && st.mode != ocs_pkg::OCS_STOP) begin
			next_st.stop_int_off   = st.cfg[ocs_pkg::STOP_INT_OFF_POS];
			next_st.stop_rc_keep   = st.cfg[ocs_pkg::STOP_RC_KEEP_POS];
			next_st.stop_xtal_keep = st.cfg[ocs_pkg::STOP_XTAL_KEEP_POS];
		end
		// Oscillator enables: sysint gate, source choice, stop gating
		next_st.int_en = OSC_ENABLE_FROM_SYSINT; // (R6) (R13)
		next_st.rc_en  = OSC_ENABLE_FROM_SYSINT &&
			st.opt_loaded && (main_sel == ocs_pkg::MAIN_RC); // (R15)
		next_st.xtal_en = OSC_ENABLE_FROM_SYSINT &&
			st.opt_loaded && (main_sel == ocs_pkg::MAIN_XTAL); // (R15)
		if (st.mode == ocs_pkg::OCS_STOP) begin
			if (st.stop_int_off) begin
				next_st.int_en = 1'b0; // (R10)
			end
			if (!st.stop_rc_keep) begin
				next_st.rc_en = 1'b0; // (R9)
			end
			if (!st.stop_xtal_keep) begin
				next_st.xtal_en = 1'b0; // (R9)
			end
		end
	end

	// State register
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			st <= '{cfg: ocs_pkg::CFG_RESET,
				option: ocs_pkg::OPTION_RESET,
				opt_loaded: 1'b0,
				mode: ocs_pkg::OCS_RUN,
				stop_int_off: 1'b0,
				stop_rc_keep: 1'b0,
				stop_xtal_keep: 1'b0,
				int_en: 1'b1,
				rc_en: 1'b0,
				xtal_en: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// Enables leave the block from flip-flops
	assign INTERNAL_OSC_EN = st.int_en;
	assign RC_OSC_EN       = st.rc_en;
	assign CRYSTAL_OSC_EN  = st.xtal_en;

	// Main clock mux; plain gating, so selection must stay static
	always_comb begin
		unique case (main_sel)
			ocs_pkg::MAIN_INT:  main_clk = INTERNAL_OSC_CLOCK &
				st.int_en; // (R2) (R8)
			ocs_pkg::MAIN_RC:   main_clk = RC_OSC_CLOCK & st.rc_en; // (R2)
			ocs_pkg::MAIN_XTAL: main_clk = CRYSTAL_OSC_CLOCK &
				st.xtal_en; // (R2)
			default:            main_clk = 1'b0; // (R2) (R16)
		endcase
	end

	assign MAIN_REF_CLOCK = main_clk;
	assign PLL_REF_CLOCK  = main_clk; // (R14)

	// Timebase clock; RC or crystal only when also the main source
	always_comb begin
		unique case (tb_sel)
			ocs_pkg::TB_INT:  TIMEBASE_REF_CLOCK = INTERNAL_OSC_CLOCK &
				st.int_en; // (R4)
			ocs_pkg::TB_RC:   TIMEBASE_REF_CLOCK = RC_OSC_CLOCK &
				st.rc_en & (main_sel == ocs_pkg::MAIN_RC); // (R5)
			ocs_pkg::TB_XTAL: TIMEBASE_REF_CLOCK = CRYSTAL_OSC_CLOCK &
				st.xtal_en & (main_sel == ocs_pkg::MAIN_XTAL); // (R5)
			default:          TIMEBASE_REF_CLOCK = 1'b0; // (R4)
		endcase
	end

	// Watchdog is tied to the internal oscillator regardless of selects
	assign WATCHDOG_REF_CLOCK = INTERNAL_OSC_CLOCK & st.int_en; // (R7)

	// Second oscillator pin drive
	assign OSC_OUTPUT_PIN = (main_sel == ocs_pkg::MAIN_XTAL) ?
		XTAL_AMP_OUT : BUS_CLOCK; // (R3)

endmodule : ocs_top

// File: sim/ocs_osc_model.sv
// Behavioural oscillators feeding the clock select block
`timescale 1ns/10ps
module ocs_osc_model (
	input  wire logic clk,      // Bench clock
	input  wire logic int_en,   // Internal osc enable
	input  wire logic rc_en,    // RC osc enable
	input  wire logic xtal_en,  // Crystal osc enable
	output logic      int_clk,  // Internal osc clock
	output logic      rc_clk,   // RC osc clock
	output logic      xtal_clk, // Crystal osc clock
	output logic      amp_out   // Inverting amp output
);
	logic [2:0] cnt = 3'h0;
	// Free divider; rates differ so sources can be told apart
	always_ff @(posedge clk) begin
		cnt <= cnt + 3'h1;
	end
	// A powered-down oscillator sits low
	assign int_clk  = int_en & cnt[0];
	assign rc_clk   = rc_en & cnt[1];
	assign xtal_clk = xtal_en & cnt[2];
	assign amp_out  = ~xtal_clk;
endmodule : ocs_osc_model

// File: sim/ocs_checker.sv
// Port assertions for the oscillator clock select block
`timescale 1ns/10ps
module ocs_checker (
	input wire logic       CLK,                    // Clock
	input wire logic       RESET_N,                // Reset
	input wire logic [7:0] OPTION_BYTE,            // Option
	input wire logic       OSC_ENABLE_FROM_SYSINT, // Osc enable
	input wire logic       STOP_REQ,               // Stop
	input wire logic       WAIT_REQ,               // Wait
	input wire logic       BUS_CLOCK,              // Bus clock
	input wire logic       INTERNAL_OSC_CLOCK,     // Internal clk
	input wire logic       RC_OSC_CLOCK,           // RC clk
	input wire logic       CRYSTAL_OSC_CLOCK,      // Crystal clk
	input wire logic       XTAL_AMP_OUT,           // Amp out
	input wire logic       INTERNAL_OSC_EN,        // Internal en
	input wire logic       RC_OSC_EN,              // RC en
	input wire logic       CRYSTAL_OSC_EN,         // Crystal en
	input wire logic       MAIN_REF_CLOCK,         // Main ref
	input wire logic       PLL_REF_CLOCK,          // PLL ref
	input wire logic       WATCHDOG_REF_CLOCK,     // Watchdog ref
	input wire logic       OSC_OUTPUT_PIN          // Second pin
);
	logic [1:0] cyc;
	logic [1:0] sel;
	logic       exp_main;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// Option is loaded after release, so wait until it has settled
	always_ff @(posedge CLK) begin
		cyc <= !RESET_N ? 2'h0 : (cyc == 2'h3 ? cyc : cyc + 2'h1);
	end
	assign sel = OPTION_BYTE[1:0];
	// Expected main clock from the option code
	always_comb begin
		case (sel)
			ocs_pkg::MAIN_INT:  exp_main = INTERNAL_OSC_CLOCK;
			ocs_pkg::MAIN_RC:   exp_main = RC_OSC_CLOCK;
			ocs_pkg::MAIN_XTAL: exp_main = CRYSTAL_OSC_CLOCK;
			default:            exp_main = 1'b0;
		endcase
	end
	property p_pll;
		PLL_REF_CLOCK == MAIN_REF_CLOCK;
	endproperty
	property p_wdog;
		WATCHDOG_REF_CLOCK == (INTERNAL_OSC_CLOCK & INTERNAL_OSC_EN);
	endproperty
	property p_excl;
		!(RC_OSC_EN && CRYSTAL_OSC_EN);
	endproperty
	property p_pin;
		cyc == 2'h3 |-> OSC_OUTPUT_PIN ==
			(sel == 2'h3 ? XTAL_AMP_OUT : BUS_CLOCK);
	endproperty
	property p_main;
		cyc == 2'h3 |-> MAIN_REF_CLOCK == exp_main;
	endproperty
	property p_rst;
		disable iff (1'b0)
		!RESET_N |=> INTERNAL_OSC_EN && !RC_OSC_EN && !CRYSTAL_OSC_EN;
	endproperty
	property p_wait;
		(cyc == 2'h3 && !STOP_REQ && OSC_ENABLE_FROM_SYSINT)[*8] ##1
			WAIT_REQ |-> $stable({INTERNAL_OSC_EN, CRYSTAL_OSC_EN});
	endproperty
	property p_sysen;
		!OSC_ENABLE_FROM_SYSINT[*3] |->
			!INTERNAL_OSC_EN && !RC_OSC_EN && !CRYSTAL_OSC_EN;
	endproperty
	a_pll: assert property (p_pll)
		else $error("pll ref differs from main");
	a_wdog: assert property (p_wdog)
		else $error("watchdog clock wrong");
	a_excl: assert property (p_excl)
		else $error("rc and crystal both on");
	a_pin: assert property (p_pin)
		else $error("second pin wrong");
	a_main: assert property (p_main)
		else $error("main clock wrong");
	a_rst: assert property (p_rst)
		else $error("enables wrong after reset");
	a_wait: assert property (p_wait)
		else $error("wait moved enables");
	a_sysen: assert property (p_sysen)
		else $error("oscillator on while disabled");
	c_xtal: cover property (cyc == 2'h3 && sel == 2'h3);
	c_stop: cover property (STOP_REQ && !CRYSTAL_OSC_EN);
	c_wait: cover property (WAIT_REQ);
endmodule : ocs_checker

bind ocs_top ocs_checker chk_u (.*);

// File: sim/tb_top.sv
// Self-checking bench for the oscillator clock select block
`timescale 1ns/10ps
module tb_top;
	logic        CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0;
	logic        PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR;
	logic [17:0] PADDR = 18'h00000;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic [7:0]  OPTION_BYTE = 8'h00;
	logic        OSC_ENABLE_FROM_SYSINT = 1'b1, BUS_CLOCK = 1'b0;
	logic        STOP_REQ = 1'b0, WAIT_REQ = 1'b0, BREAK_REQ = 1'b0;
	logic        INTERNAL_OSC_CLOCK, RC_OSC_CLOCK, CRYSTAL_OSC_CLOCK;
	logic        XTAL_AMP_OUT, INTERNAL_OSC_EN, RC_OSC_EN;
	logic        CRYSTAL_OSC_EN, MAIN_REF_CLOCK, PLL_REF_CLOCK;
	logic        TIMEBASE_REF_CLOCK, WATCHDOG_REF_CLOCK, OSC_OUTPUT_PIN;
	int          err_count = 0, check_count = 0;
	ocs_top dut_u (.*);
	ocs_osc_model osc_u (.clk(CLK), .int_en(INTERNAL_OSC_EN),
		.rc_en(RC_OSC_EN), .xtal_en(CRYSTAL_OSC_EN),
		.int_clk(INTERNAL_OSC_CLOCK), .rc_clk(RC_OSC_CLOCK),
		.xtal_clk(CRYSTAL_OSC_CLOCK), .amp_out(XTAL_AMP_OUT));
	// 100 ns clock and a slower bus clock
	initial forever #50 CLK = ~CLK;
	always @(posedge CLK) BUS_CLOCK <= ~BUS_CLOCK;
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	// One APB transfer; zero wait states, but wait is still bounded
	task automatic apb(logic w, logic [17:0] a, logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n = 0;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			end_sim;
		end
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic rw(logic w, string n, logic [17:0] a, logic [31:0] d,
		logic [31:0] x, logic ee);
		logic [31:0] r;
		logic        e;
		apb(w, a, d, r, e);
		if (!w) chk(n, r, x);
		chk(n, e, ee);
	endtask : rw
	task automatic rst(logic [1:0] s);
		@(posedge CLK);
		RESET_N <= 1'b0;
		OPTION_BYTE <= {6'h00, s};
		repeat (12) @(posedge CLK);
		RESET_N <= 1'b1;
		repeat (3) @(posedge CLK);
	endtask : rst
	task automatic ens(logic i, logic r, logic x);
		@(negedge CLK);
		chk("int_en", INTERNAL_OSC_EN, i);
		chk("rc_en", RC_OSC_EN, r);
		chk("xtal_en", CRYSTAL_OSC_EN, x);
	endtask : ens
	// Every main code against every timebase code
	task automatic t_sel(logic [1:0] s);
		logic t;
		rst(s);
		ens(1'b1, s == 2'h2, s == 2'h3);
		rw(0, "cfg", ocs_pkg::ADDR_TB_STOP_CFG, 0, 0, 0);
		rw(0, "opt", ocs_pkg::ADDR_MAIN_OPTION, 0, s, 0);
		rw(0, "st", ocs_pkg::ADDR_OSC_STATUS, 0,
			{3'h0, s == 2'h3, s == 2'h2, 1'b1, s}, 0);
		for (int b = 0; b < 4; b++) begin
			rw(1, "wcfg", ocs_pkg::ADDR_TB_STOP_CFG, b, 0, 0);
			repeat (8) begin
				@(negedge CLK);
				t = b == 0 ? INTERNAL_OSC_CLOCK : b == 1 ?
					RC_OSC_CLOCK & (s == 2'h2) : b == 2 ?
					CRYSTAL_OSC_CLOCK & (s == 2'h3) : 1'b0;
				chk("tb", TIMEBASE_REF_CLOCK, t);
				t = s == 1 ? INTERNAL_OSC_CLOCK : s == 2 ?
					RC_OSC_CLOCK : s == 3 ? CRYSTAL_OSC_CLOCK : 1'b0;
				chk("main", MAIN_REF_CLOCK, t);
				chk("pll", PLL_REF_CLOCK, t);
				chk("pin", OSC_OUTPUT_PIN,
					s == 3 ? XTAL_AMP_OUT : BUS_CLOCK);
			end
		end
		$display("test sel %0d done", s);
	endtask : t_sel
	task automatic t_regs;
		rw(1, "wcfg", ocs_pkg::ADDR_TB_STOP_CFG, 8'h1F, 0, 0);
		rw(0, "cfg", ocs_pkg::ADDR_TB_STOP_CFG, 0, 8'h1F, 0);
		rw(1, "wopt", ocs_pkg::ADDR_MAIN_OPTION, 0, 0, 1);
		rw(0, "opt", ocs_pkg::ADDR_MAIN_OPTION, 0, 8'h03, 0);
		rw(0, "unmap", 18'h00040, 0, 0, 1);
		$display("test regs done");
	endtask : t_regs
	// Stop with a keep/off pattern, then release
	task automatic t_stop(logic [1:0] s, logic [7:0] c, logic i,
		logic r, logic x);
		rst(s);
		rw(1, "wcfg", ocs_pkg::ADDR_TB_STOP_CFG, c, 0, 0);
		STOP_REQ <= 1'b1;
		repeat (10) @(posedge CLK);
		ens(i, r, x);
		rw(0, "st", ocs_pkg::ADDR_OSC_STATUS, 0,
			{3'h6, x, r, i, s}, 0);
		STOP_REQ <= 1'b0;
		repeat (10) @(posedge CLK);
		ens(1'b1, s == 2'h2, s == 2'h3);
		$display("test stop %h done", c);
	endtask : t_stop
	task automatic t_mode;
		// Mode checks expect the crystal as main source
		rst(2'h3);
		for (int m = 1; m < 3; m++) begin
			@(posedge CLK);
			WAIT_REQ <= m == 1;
			BREAK_REQ <= m == 2;
			repeat (6) @(negedge CLK);
			chk("main", MAIN_REF_CLOCK, CRYSTAL_OSC_CLOCK);
			ens(1'b1, 1'b0, 1'b1);
			rw(0, "st", ocs_pkg::ADDR_OSC_STATUS, 0,
				{m[1:0], 6'h17}, 0);
		end
		WAIT_REQ <= 1'b0;
		BREAK_REQ <= 1'b0;
		OSC_ENABLE_FROM_SYSINT <= 1'b0;
		repeat (5) @(posedge CLK);
		ens(1'b0, 1'b0, 1'b0);
		chk("wdog", WATCHDOG_REF_CLOCK, 1'b0);
		@(posedge CLK);
		OSC_ENABLE_FROM_SYSINT <= 1'b1;
		repeat (5) @(posedge CLK);
		ens(1'b1, 1'b0, 1'b1);
		$display("test modes done");
	endtask : t_mode
	initial begin
		for (int s = 0; s < 4; s++) t_sel(s[1:0]);
		t_regs;
		t_stop(2'h3, 8'h00, 1'b1, 1'b0, 1'b0);
		t_stop(2'h3, 8'h18, 1'b0, 1'b0, 1'b1);
		t_stop(2'h2, 8'h04, 1'b1, 1'b1, 1'b0);
		t_mode;
		end_sim;
	end
endmodule : tb_top
